// File: fwc_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash write control.
// Assumes a 25 MHz system clock and a 32-bit APB bus.
// How it works
// - Word program writes one 32-bit word from address and data registers, ones to zeros
// - Word program select clears itself when the word program ends
// - Suspend halts program or erase, bank back to read, busy flags cleared
// - During erase suspend, erase resume or unsuspendable program are accepted
// - Operations launch only on write start, using the select bit set then
// - Write start clears itself at operation end and on suspend
// - Write start with the error flag high is rejected
// - Writing zero to write start does nothing; only hardware clears it
// - Secondary module: sector bits 2:0 pick bank-2 sectors and show status
// - Primary module: sector bits 9:0 pick bank-0 sectors and show status
// - Bank-2 sector bits clear at end of an error-free operation
// - Bank-0 sector bits clear at end of an error-free operation
// - Module select: clear means secondary, set means primary; clears at end, back to the parked erase's choice after a nested program
// - Sector bit means erase error if error set, else suspended if suspend set
// - Sector erase wipes chosen sectors of one bank; select clears at end
`ifndef FWC_CFG_SVH
`define FWC_CFG_SVH
`define FWC_CTRL_ADDR 32'h000E_0000
`define FWC_SECT_ADDR 32'h000E_0004
`define FWC_DATA_ADDR 32'h000E_0008
`define FWC_PADR_ADDR 32'h000E_0010
`define FWC_ERR_ADDR 32'h000E_0014
`define FWC_B_START 15
`define FWC_B_SUSPEND_REQUEST 14
`define FWC_B_WPG 13
`define FWC_B_DOUBLE_WORD_PROGRAM_SELECT 12
`define FWC_B_SER 11
`define FWC_B_MODULE_SELECT 0
`define FWC_B_ERR 0
`define FWC_B_SEQ 1
`define FWC_DATA_RST 32'hFFFF_FFFF
`define FWC_CLK_NS 40
`define FWC_PROG_NS 20000
`define FWC_ERASE_NS 1500000
`define FWC_PROG_CYC ((`FWC_PROG_NS + `FWC_CLK_NS - 1) / `FWC_CLK_NS)
`define FWC_ERASE_CYC ((`FWC_ERASE_NS + `FWC_CLK_NS - 1) / `FWC_CLK_NS)
`endif

// File: fwc_pkg.sv
// Types of the flash write control: states, operations and carriers.
// Assumes nothing beyond the configuration header.
package fwc_pkg;
    typedef enum logic [2:0] {
        FWC_IDLE = 3'h0,
        FWC_RUN  = 3'h1,
        FWC_SUSPEND_REQUEST = 3'h3,
        FWC_NEST = 3'h2
    } fwc_state_t;
    typedef enum logic [1:0] {
        FWC_OP_NONE  = 2'h0,
        FWC_OP_WORD  = 2'h1,
        FWC_OP_DWORD = 2'h2,
        FWC_OP_ERASE = 2'h3
    } fwc_op_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } fwc_apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fwc_apb_rsp_t;
    typedef struct packed {
        logic        strobe;
        fwc_op_t     kind;
        logic        primary;
        logic [23:0] addr;
        logic [31:0] data;
        logic [9:0]  sectors;
        logic [1:0]  bank_busy;
    } fwc_op_cmd_t;
    typedef struct packed {
        fwc_state_t   state;
        fwc_op_t      kind;
        logic         write_start;
        logic         suspend_request;
        logic         word_program_select;
        logic         double_word_program_select;
        logic         sector_erase_select;
        logic         module_select;
        logic         suspend_request_module;
        logic         err;
        logic         seq_err;
        logic [9:0]   sectors;
        logic [23:0]  addr;
        logic [31:0]  data;
        logic [15:0]  cnt;
        logic [15:0]  nest_cnt;
        fwc_apb_rsp_t rsp;
        fwc_op_cmd_t  op;
    } fwc_state_reg_t;
endpackage

// File: fwc_flash_write_ctrl.sv
// Flash write control: program/erase launch, suspend and resume, sector status, APB slave.
// Assumes the flash array takes o_op.strobe and reports failure on i_op_fail at the end.
`timescale 1ns/1ns
`include "fwc_cfg.svh"
module fwc_flash_write_ctrl
    import fwc_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = `FWC_ERASE_CYC
) (
    input  logic         i_clk,
    input  logic         i_rst_n,
    input  fwc_apb_req_t i_apb,
    input  logic         i_op_fail,
    output fwc_apb_rsp_t o_apb,
    output fwc_op_cmd_t  o_op
);
    localparam logic [15:0] PROG_CYC  = 16'(`FWC_PROG_CYC);
    localparam logic [15:0] ERASE_CYC = 16'(ERASE_CYCLES);

    fwc_state_reg_t s;
    fwc_state_reg_t next_s;

    always_comb begin
        logic        setup;
        logic        acc_wr;
        logic        hit;
        logic [31:0] rd;
        logic [31:0] wd;
        fwc_op_t     req;
        logic        req_mod;
        next_s = s;
        setup = i_apb.psel & ~i_apb.penable;
        acc_wr = i_apb.psel & i_apb.penable & s.rsp.pready & i_apb.pwrite;
        wd = i_apb.pwdata;
        hit = 1'b1;
        rd = 32'h0000_0000;
        req = FWC_OP_NONE;
        req_mod = wd[`FWC_B_MODULE_SELECT];
        next_s.op.strobe = 1'b0;

        // Read data captured at setup, answered one cycle later
        case (i_apb.paddr)
            `FWC_CTRL_ADDR: begin
                rd[`FWC_B_START] = s.write_start;
                rd[`FWC_B_SUSPEND_REQUEST] = s.suspend_request;
                rd[`FWC_B_WPG] = s.word_program_select;
                rd[`FWC_B_DOUBLE_WORD_PROGRAM_SELECT] = s.double_word_program_select;
                rd[`FWC_B_SER] = s.sector_erase_select;
                rd[`FWC_B_MODULE_SELECT] = s.module_select;
            end
            `FWC_SECT_ADDR: begin
                if (s.module_select) begin
                    rd[9:0] = s.sectors;
                end else begin
                    rd[2:0] = s.sectors[2:0];
                end
            end
            `FWC_DATA_ADDR: begin
                rd = s.data;
            end
            `FWC_PADR_ADDR: begin
                rd[23:0] = s.addr;
            end
            `FWC_ERR_ADDR: begin
                rd[`FWC_B_ERR] = s.err;
                rd[`FWC_B_SEQ] = s.seq_err;
                rd[3:2] = s.op.bank_busy;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (setup) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.pslverr = ~hit;
            next_s.rsp.prdata = rd;
        end else begin
            next_s.rsp.pready = 1'b0;
            next_s.rsp.pslverr = 1'b0;
        end

        // Flag clears first so a hardware set in the same cycle wins
        if (acc_wr && i_apb.paddr == `FWC_ERR_ADDR) begin
            if (wd[`FWC_B_ERR]) begin
                next_s.err = 1'b0;
            end
            if (wd[`FWC_B_SEQ]) begin
                next_s.seq_err = 1'b0;
            end
        end

        // Operation timing
        case (s.state)
            FWC_RUN: begin
                if (s.cnt == 16'h0000) begin
                    next_s.state = FWC_IDLE;
                    next_s.kind = FWC_OP_NONE;
                    next_s.write_start = 1'b0;
                    next_s.word_program_select = 1'b0;
                    next_s.double_word_program_select = 1'b0;
                    next_s.sector_erase_select = 1'b0;
                    next_s.module_select = 1'b0;
                    next_s.op.bank_busy = 2'h0;
                    if (i_op_fail) begin
                        next_s.err = 1'b1;
                    end else begin
                        next_s.sectors = 10'h000;
                    end
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            FWC_NEST: begin
                // Program inside erase suspend; the erase stays parked
                if (s.nest_cnt == 16'h0000) begin
                    next_s.state = FWC_SUSPEND_REQUEST;
                    next_s.write_start = 1'b0;
                    next_s.word_program_select = 1'b0;
                    next_s.double_word_program_select = 1'b0;
                    next_s.module_select = s.suspend_request_module;
                    // Parked erase reads as suspended again
                    next_s.suspend_request = 1'b1;
                    next_s.op.bank_busy = 2'h0;
                    if (i_op_fail) begin
                        next_s.err = 1'b1;
                    end
                end else begin
                    next_s.nest_cnt = s.nest_cnt - 16'h0001;
                end
            end
            default: begin
            end
        endcase

        // Control register writes
        if (acc_wr && i_apb.paddr == `FWC_CTRL_ADDR) begin
            if (s.state == FWC_RUN) begin
                if (wd[`FWC_B_SUSPEND_REQUEST] && s.cnt != 16'h0000) begin
                    next_s.state = FWC_SUSPEND_REQUEST;
                    next_s.suspend_request = 1'b1;
                    next_s.write_start = 1'b0;
                    next_s.op.bank_busy = 2'h0;
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end else if (s.state == FWC_IDLE || s.state == FWC_SUSPEND_REQUEST) begin
                next_s.suspend_request = wd[`FWC_B_SUSPEND_REQUEST];
                next_s.word_program_select = wd[`FWC_B_WPG];
                next_s.double_word_program_select = wd[`FWC_B_DOUBLE_WORD_PROGRAM_SELECT];
                next_s.sector_erase_select = wd[`FWC_B_SER];
                next_s.module_select = req_mod;
                // Exactly one select bit names the operation
                case ({wd[`FWC_B_WPG], wd[`FWC_B_DOUBLE_WORD_PROGRAM_SELECT], wd[`FWC_B_SER]})
                    3'h4: req = FWC_OP_WORD;
                    3'h2: req = FWC_OP_DWORD;
                    3'h1: req = FWC_OP_ERASE;
                    default: req = FWC_OP_NONE;
                endcase
                // Zero in the start bit is ignored
                if (wd[`FWC_B_START]) begin
                    if (s.err || req == FWC_OP_NONE) begin
                        next_s.seq_err = 1'b1;
                    end else if (s.state == FWC_IDLE) begin
                        // Rejected rather than trusting software
                        if (wd[`FWC_B_SUSPEND_REQUEST] ||
                            (req == FWC_OP_ERASE && s.sectors == 10'h000)) begin
                            next_s.seq_err = 1'b1;
                        end else begin
                            next_s.state = FWC_RUN;
                            next_s.kind = req;
                            next_s.write_start = 1'b1;
                            next_s.suspend_request_module = req_mod;
                            next_s.cnt = (req == FWC_OP_ERASE) ? ERASE_CYC : PROG_CYC;
                            next_s.op.strobe = 1'b1;
                            next_s.op.kind = req;
                            next_s.op.primary = req_mod;
                            next_s.op.addr = s.addr;
                            next_s.op.data = s.data;
                            next_s.op.sectors = (req == FWC_OP_ERASE) ?
                                s.sectors : 10'h000;
                            next_s.op.bank_busy = req_mod ? 2'h2 : 2'h1;
                        end
                    end else if (req == s.kind) begin
                        next_s.state = FWC_RUN;
                        next_s.write_start = 1'b1;
                        next_s.suspend_request = 1'b0;
                        next_s.module_select = s.suspend_request_module;
                        next_s.op.strobe = 1'b1;
                        next_s.op.kind = req;
                        next_s.op.primary = s.suspend_request_module;
                        // A nested program overwrote the sector copy
                        next_s.op.sectors = (req == FWC_OP_ERASE) ? s.sectors : 10'h000;
                        next_s.op.bank_busy = s.suspend_request_module ? 2'h2 : 2'h1;
                    end else if (s.kind == FWC_OP_ERASE && req != FWC_OP_ERASE) begin
                        next_s.state = FWC_NEST;
                        next_s.write_start = 1'b1;
                        next_s.nest_cnt = PROG_CYC;
                        next_s.op.strobe = 1'b1;
                        next_s.op.kind = req;
                        next_s.op.primary = req_mod;
                        next_s.op.addr = s.addr;
                        next_s.op.data = s.data;
                        next_s.op.sectors = 10'h000;
                        next_s.op.bank_busy = req_mod ? 2'h2 : 2'h1;
                    end else begin
                        next_s.seq_err = 1'b1;
                    end
                end
            end
        end

        // Sector choice held still while anything is in flight
        if (acc_wr && i_apb.paddr == `FWC_SECT_ADDR && s.state == FWC_IDLE) begin
            if (s.module_select) begin
                next_s.sectors = wd[9:0];
            end else begin
                next_s.sectors = {7'h00, wd[2:0]};
            end
        end
        if (acc_wr && (s.state == FWC_IDLE || s.state == FWC_SUSPEND_REQUEST)) begin
            if (i_apb.paddr == `FWC_DATA_ADDR) begin
                next_s.data = wd;
            end
            if (i_apb.paddr == `FWC_PADR_ADDR) begin
                next_s.addr = wd[23:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.state <= FWC_IDLE;
            s.kind <= FWC_OP_NONE;
            s.data <= `FWC_DATA_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_apb = s.rsp;
    assign o_op = s.op;
endmodule // fwc_flash_write_ctrl

// File: fwc_asserts.sv
// Port checker for the flash write control.
// Assumes binding into fwc_flash_write_ctrl on one clock.
`timescale 1ns/1ns
`include "fwc_cfg.svh"
module fwc_asserts
    import fwc_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 20
) (
    input logic         i_clk,
    input logic         i_rst_n,
    input fwc_apb_req_t i_apb,
    input logic         i_op_fail,
    input fwc_apb_rsp_t o_apb,
    input fwc_op_cmd_t  o_op
);
    // Program time is fixed, so the bound is the longer of the two runs
    localparam int LIM = (ERASE_CYCLES > 500) ? ERASE_CYCLES + 3 : 504;
    logic [31:0] busy_run;
    logic        start_w;
    assign start_w = i_apb.psel && i_apb.penable && i_apb.pwrite
                     && i_apb.paddr == `FWC_CTRL_ADDR && i_apb.pwdata[`FWC_B_START];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_run <= 32'h0;
        end else begin
            busy_run <= (o_op.bank_busy != 2'h0) ? busy_run + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_setup;
        i_apb.psel && !i_apb.penable;
    endsequence
    sequence s_launch;
        start_w ##1 o_op.strobe;
    endsequence
    a_setup_ready: assert property (s_setup |=> o_apb.pready) else $error("no ready");
    a_ready_single: assert property (o_apb.pready |=> !o_apb.pready) else $error("long ready");
    a_error_read: assert property (o_apb.pslverr |-> o_apb.pready && o_apb.prdata == 32'h0)
        else $error("bad error reply");
    a_strobe_cause: assert property (o_op.strobe |-> $past(start_w)) else $error("stray op");
    a_strobe_pulse: assert property (o_op.strobe |=> !o_op.strobe) else $error("long strobe");
    a_launch_busy: assert property (s_launch |-> o_op.bank_busy == (o_op.primary ? 2'h2 : 2'h1))
        else $error("busy mismatch");
    a_prog_nosect: assert property (o_op.strobe && o_op.kind != FWC_OP_ERASE
        |-> o_op.sectors == 10'h0) else $error("program sectors");
    a_erase_sect: assert property (o_op.strobe && o_op.kind == FWC_OP_ERASE
        |-> o_op.sectors != 10'h0 && (o_op.primary || o_op.sectors[9:3] == 7'h0))
        else $error("erase sectors");
    a_busy_bound: assert property (busy_run <= LIM) else $error("busy too long");
endmodule // fwc_asserts

bind fwc_flash_write_ctrl fwc_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(i_apb),
    .i_op_fail(i_op_fail), .o_apb(o_apb), .o_op(o_op));

// File: fwc_tb.sv
// Directed bench for the flash write control over APB.
// Assumes ERASE_CYCLES of 20; the array is stood in for by i_op_fail.
`timescale 1ns/1ns
`include "fwc_cfg.svh"
module tb;
    import fwc_pkg::*;
    logic         i_clk;
    logic         i_rst_n;
    logic         fail;
    fwc_apb_req_t apb;
    fwc_apb_rsp_t rsp;
    fwc_op_cmd_t  op;
    logic [31:0]  strobes;
    logic         last_err;
    int           bad_count;
    int           checks;
    fwc_flash_write_ctrl #(.ERASE_CYCLES(20)) dut (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_apb    (apb),
        .i_op_fail(fail),
        .o_apb    (rsp),
        .o_op     (op)
    );
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Counted mid-cycle so the launching edge never races the count
    always @(negedge i_clk) begin
        if (!i_rst_n) begin
            strobes <= 32'h0;
        end else if (op.strobe === 1'b1) begin
            strobes <= strobes + 32'h1;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        int n;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        r = rsp.prdata;
        last_err = rsp.pslverr;
        apb <= '0;
        @(posedge i_clk);
        if (n == 50) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] v;
        xfer(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [31:0] a, m, e, input string s);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(s, e, v & m);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (op.bank_busy !== 2'h0 && n < 700) begin
            @(posedge i_clk);
            n++;
        end
        if (n == 700) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic t_reset;
        rd(`FWC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl");
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h0, "sect");
        rd(`FWC_DATA_ADDR, 32'hFFFFFFFF, `FWC_DATA_RST, "data");
        rd(`FWC_ERR_ADDR, 32'hFFFFFFFF, 32'h0, "err");
        rd(32'h000E000C, 32'hFFFFFFFF, 32'h0, "hole");
        chk("slverr", 32'h1, {31'h0, last_err});
        $display("t_reset done");
    endtask
    task automatic t_word;
        wr(`FWC_PADR_ADDR, 32'h00123456);
        wr(`FWC_DATA_ADDR, 32'h5A5AA5A5);
        wr(`FWC_CTRL_ADDR, 32'h0000A001);
        chk("strobes", 32'h1, strobes);
        chk("kind", 32'h1, {30'h0, op.kind});
        chk("addr", 32'h00123456, {8'h0, op.addr});
        chk("data", 32'h5A5AA5A5, op.data);
        chk("primary", 32'h1, {31'h0, op.primary});
        wr(`FWC_CTRL_ADDR, 32'h00002001);
        rd(`FWC_CTRL_ADDR, 32'h0000A001, 32'h0000A001, "ctrl");
        wait_idle();
        rd(`FWC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl");
        wr(`FWC_CTRL_ADDR, 32'h00009000);
        chk("kind", 32'h2, {30'h0, op.kind});
        chk("primary", 32'h0, {31'h0, op.primary});
        wait_idle();
        rd(`FWC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl");
        $display("t_word done");
    endtask
    task automatic t_fail;
        wr(`FWC_SECT_ADDR, 32'h000003FF);
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h7, "sect");
        fail <= 1'b1;
        wr(`FWC_CTRL_ADDR, 32'h00008800);
        chk("sectors", 32'h7, {22'h0, op.sectors});
        wait_idle();
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h7, "sect");
        rd(`FWC_ERR_ADDR, 32'hFFFFFFFF, 32'h1, "err");
        wr(`FWC_CTRL_ADDR, 32'h0000A000);
        rd(`FWC_CTRL_ADDR, 32'h00008000, 32'h0, "ctrl");
        rd(`FWC_ERR_ADDR, 32'h3, 32'h3, "err");
        fail <= 1'b0;
        wr(`FWC_ERR_ADDR, 32'h3);
        rd(`FWC_ERR_ADDR, 32'hFFFFFFFF, 32'h0, "err");
        $display("t_fail done");
    endtask
    task automatic t_erase;
        logic [31:0] s0;
        s0 = strobes;
        wr(`FWC_CTRL_ADDR, 32'h00000001);
        wr(`FWC_SECT_ADDR, 32'h000003FF);
        wr(`FWC_CTRL_ADDR, 32'h00008801);
        chk("sectors", 32'h3FF, {22'h0, op.sectors});
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h3FF, "sect");
        wr(`FWC_CTRL_ADDR, 32'h00004801);
        chk("busy", 32'h0, {30'h0, op.bank_busy});
        rd(`FWC_CTRL_ADDR, 32'h00008000, 32'h0, "ctrl");
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h3FF, "sect");
        wr(`FWC_CTRL_ADDR, 32'h0000A000);
        chk("strobes", s0 + 32'h2, strobes);
        wait_idle();
        rd(`FWC_CTRL_ADDR, 32'h00004000, 32'h00004000, "ctrl");
        wr(`FWC_CTRL_ADDR, 32'h00008801);
        chk("kind", 32'h3, {30'h0, op.kind});
        wait_idle();
        rd(`FWC_SECT_ADDR, 32'hFFFFFFFF, 32'h0, "sect");
        rd(`FWC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl");
        $display("t_erase done");
    endtask
    task automatic t_prog_suspend_request;
        logic [31:0] s0;
        wr(`FWC_SECT_ADDR, 32'h1);
        wr(`FWC_CTRL_ADDR, 32'h0000A000);
        wr(`FWC_CTRL_ADDR, 32'h00004000);
        s0 = strobes;
        wr(`FWC_CTRL_ADDR, 32'h00008800);
        chk("strobes", s0, strobes);
        rd(`FWC_ERR_ADDR, 32'h2, 32'h2, "err");
        wr(`FWC_ERR_ADDR, 32'h2);
        wr(`FWC_CTRL_ADDR, 32'h0000A000);
        chk("strobes", s0 + 32'h1, strobes);
        wait_idle();
        rd(`FWC_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, "ctrl");
        s0 = strobes;
        wr(`FWC_CTRL_ADDR, 32'h0000E000);
        chk("strobes", s0, strobes);
        rd(`FWC_ERR_ADDR, 32'h2, 32'h2, "err");
        wr(`FWC_ERR_ADDR, 32'h2);
        $display("t_prog_suspend_request done");
    endtask
    initial begin
        apb = '0;
        fail = 1'b0;
        i_rst_n = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_word();
        t_fail();
        t_erase();
        t_prog_suspend_request();
        finish_test();
    end
endmodule // tb
